// ===== rtl/eelr_params.svh
`ifndef EELR_PARAMS_SVH
`define EELR_PARAMS_SVH

`define EELR_CLK_PERIOD_NS   10
`define EELR_MS_NS           1000000
`define EELR_CYC_PER_MS      (`EELR_MS_NS / `EELR_CLK_PERIOD_NS)
`define EELR_HOUR_MS         3600000

`define EELR_LOG_SECTORS     64
`define EELR_ENTRIES         256
`define EELR_ENTRY_BYTES     124
`define EELR_SNAP_BYTES      18
`define EELR_SNAPS           5
`define EELR_ERRD_BYTES      34
`define EELR_SECTOR_LAST     9'd511
`define EELR_ENTRY0_OFS      9'd4
`define EELR_HDR_VERSION     9'd0
`define EELR_HDR_IDX_LO      9'd2
`define EELR_HDR_IDX_HI      9'd3
`define EELR_HDR_CNT_LO      9'd500
`define EELR_HDR_CNT_HI      9'd501
`define EELR_ENTRY_END       9'd500

`define EELR_LOG_VERSION     8'h01
`define EELR_RESET_MARK      8'hFF
`define EELR_STATE_MAX       4'h4
`define EELR_STATE_UNKNOWN   4'h0

`define EELR_ADDR_CTRL       16'h8000
`define EELR_ADDR_HOUR_LO    16'h8001
`define EELR_ADDR_HOUR_HI    16'h8002
`define EELR_ADDR_STATUS     16'h8003
`define EELR_CTRL_RESET      8'h01
`define EELR_CTRL_HIST_BIT   0

`endif

// ===== rtl/eelr_pkg.sv
package eelr_pkg;
    typedef enum logic [2:0] {
        EELR_TF_DEVCTL,
        EELR_TF_FEATURES,
        EELR_TF_COUNT,
        EELR_TF_LBA_LOW,
        EELR_TF_LBA_MID,
        EELR_TF_LBA_HIGH,
        EELR_TF_DEVICE,
        EELR_TF_COMMAND
    } eelr_tf_sel_t;

    typedef enum logic {
        EELR_W_IDLE,
        EELR_W_WRITE
    } eelr_wstate_t;
endpackage

// ===== rtl/eelr_top.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eelr_params.svh"

// Summary of operation
// - After the last sector fills, the next entry overwrites the first slot (slot 0) of sector zero.
// - Wrapped log advances four entries per sector, slot by slot.
// - An index names the latest entry; unused slots read as zeros.
// - Entry is five 18-byte command snapshots then a 34-byte error description.
// - Fifth snapshot is the failing event, earlier ones its predecessors in order.
// - Missing or unretained history snapshots are zero filled.
// - A hardware reset snapshot holds FFh first and the timestamp last.
// - Command write captures control, features, count, address, device, command bytes.
// - Snapshot low byte is latest register write, high byte the one before.
// - Snapshot bytes 14 to 17 hold wrapping milliseconds since power-on.
// - Description bytes 1 to 11 hold completion registers; byte 0 reserved.
// - Description holds extended info, state code and lifetime hours.
// - For a reset, description bytes 1 to 11 may be implementation defined.
// - Description low bytes are the normal view, high bytes the high-order view.
// - State low nibble codes 0 to 4; reserved values not produced.
// - State is the mode at command write or reset arrival.
// - A lifetime counter counts device-caused errors reported while the writer is idle.
// - Rejected commands do not advance the counter.
// - The counter saturates at its maximum.
// - Byte 511 makes each sector sum to zero modulo 256.
// - The log spans 64 sectors of 512 bytes with four entries each.
// - Sector zero entries at 4, 128, 252, 376; count at 500; index at 2.
// - Sector zero byte 0 reads version 01h.
// - The index reads zero when empty and stays within 0 to 255.
module eelr_top #(
    parameter int CYC_PER_MS  = `EELR_CYC_PER_MS,
    parameter int MS_PER_HOUR = `EELR_HOUR_MS
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  tf_wr,
    input  wire eelr_pkg::eelr_tf_sel_t tf_sel,
    input  wire logic [7:0]            tf_wdata,
    input  wire logic                  hw_reset_evt,
    input  wire logic [3:0]            dev_state,
    input  wire logic                  err_log,
    input  wire logic                  err_device,
    input  wire logic                  err_is_reset,
    input  wire logic [7:0]            cmp_error,
    input  wire logic [15:0]           cmp_count,
    input  wire logic [15:0]           cmp_lba_low,
    input  wire logic [15:0]           cmp_lba_mid,
    input  wire logic [15:0]           cmp_lba_high,
    input  wire logic [7:0]            cmp_device,
    input  wire logic [7:0]            cmp_status,
    input  wire logic [151:0]          cmp_ext_info,
    input  wire logic [15:0]           reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    output logic                       log_busy,
    output logic [15:0]                err_count,
    output logic [7:0]                 log_index
);
    import eelr_pkg::*;
    localparam int SNAP_W  = `EELR_SNAP_BYTES * 8;
    localparam int ENTRY_W = `EELR_ENTRY_BYTES * 8;
    localparam int MEM_SZ  = `EELR_ENTRIES * `EELR_ENTRY_BYTES;
    if (CYC_PER_MS < 2 || MS_PER_HOUR < 2) begin : g_bad_param
        $error("eelr_top: time base counts must be at least two");
    end
    function automatic logic [14:0] mem_addr(input logic [7:0] ent, input logic [6:0] ofs);
        mem_addr = 15'(ent) * 15'd124 + 15'(ofs);
    endfunction

    // Time base: millisecond stamp and lifetime hours.
    logic [31:0] div_q, div_d;
    logic [31:0] ms_q, ms_d;
    logic [31:0] hsub_q, hsub_d;
    logic [15:0] hour_q, hour_d;
    always_comb begin
        div_d  = div_q;
        ms_d   = ms_q;
        hsub_d = hsub_q;
        hour_d = hour_q;
        if (div_q == 32'(CYC_PER_MS - 1)) begin
            div_d = '0;
            ms_d  = ms_q + 32'h00000001;
            if (hsub_q == 32'(MS_PER_HOUR - 1)) begin
                hsub_d = '0;
                hour_d = hour_q + 16'h0001;
            end else begin
                hsub_d = hsub_q + 32'h00000001;
            end
        end else begin
            div_d = div_q + 32'h00000001;
        end
        // Hours survive power cycles only through software restoring them here.
        if (reg_wr && reg_addr == `EELR_ADDR_HOUR_LO) begin
            hour_d[7:0] = reg_wdata;
        end else if (reg_wr && reg_addr == `EELR_ADDR_HOUR_HI) begin
            hour_d[15:8] = reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_q  <= '0;
            ms_q   <= '0;
            hsub_q <= '0;
            hour_q <= '0;
        end else begin
            div_q  <= div_d;
            ms_q   <= ms_d;
            hsub_q <= hsub_d;
            hour_q <= hour_d;
        end
    end

    // Task-file shadow registers and command history.
    logic [15:0]       tf16_q [5], tf16_d [5];
    logic [7:0]        devctl_q, devctl_d;
    logic [7:0]        device_q, device_d;
    logic [SNAP_W-1:0] hist_q [`EELR_SNAPS], hist_d [`EELR_SNAPS];
    logic [3:0]        state_q, state_d;
    logic              cmd_wr;
    logic              push;
    logic [SNAP_W-1:0] snap_new;

    assign cmd_wr = tf_wr && tf_sel == EELR_TF_COMMAND;
    assign push   = cmd_wr || hw_reset_evt;

    always_comb begin
        tf16_d   = tf16_q;
        devctl_d = devctl_q;
        device_d = device_q;
        hist_d   = hist_q;
        state_d  = state_q;
        if (tf_wr) begin
            case (tf_sel)
                EELR_TF_DEVCTL:   devctl_d = tf_wdata;
                EELR_TF_DEVICE:   device_d = tf_wdata;
                EELR_TF_FEATURES: tf16_d[0] = {tf16_q[0][7:0], tf_wdata};
                EELR_TF_COUNT:    tf16_d[1] = {tf16_q[1][7:0], tf_wdata};
                EELR_TF_LBA_LOW:  tf16_d[2] = {tf16_q[2][7:0], tf_wdata};
                EELR_TF_LBA_MID:  tf16_d[3] = {tf16_q[3][7:0], tf_wdata};
                EELR_TF_LBA_HIGH: tf16_d[4] = {tf16_q[4][7:0], tf_wdata};
                default:          devctl_d = devctl_q;
            endcase
        end
        if (hw_reset_evt) begin
            snap_new = {ms_q, 104'h0, `EELR_RESET_MARK};
        end else begin
            snap_new = {ms_q, 8'h00, tf_wdata, device_q, tf16_q[4], tf16_q[3],
                        tf16_q[2], tf16_q[1], tf16_q[0], devctl_q};
        end
        if (push) begin
            for (int i = 0; i < `EELR_SNAPS - 1; i++) begin
                hist_d[i] = hist_q[i+1];
            end
            hist_d[`EELR_SNAPS-1] = snap_new;
            state_d = (dev_state > `EELR_STATE_MAX) ? `EELR_STATE_UNKNOWN : dev_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tf16_q   <= '{default: '0};
            hist_q   <= '{default: '0};
            devctl_q <= '0;
            device_q <= '0;
            state_q  <= `EELR_STATE_UNKNOWN;
        end else begin
            tf16_q   <= tf16_d;
            hist_q   <= hist_d;
            devctl_q <= devctl_d;
            device_q <= device_d;
            state_q  <= state_d;
        end
    end

    // Control register: bit 0 keeps preceding history in logged entries.
    logic [7:0] ctrl_q, ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == `EELR_ADDR_CTRL) begin
            ctrl_d = reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q <= `EELR_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Entry writer: one byte per cycle into the log store.
    logic [7:0]         mem [MEM_SZ];
    logic [7:0]         sec_sum_q [`EELR_LOG_SECTORS];
    logic [`EELR_ENTRIES-1:0] used_q, used_d;
    eelr_wstate_t       ws_q, ws_d;
    logic [6:0]         k_q, k_d;
    logic [7:0]         wptr_q, wptr_d;
    logic [7:0]         idx_q, idx_d;
    logic [15:0]        cnt_q, cnt_d;
    logic [ENTRY_W-1:0] ent_q, ent_d;
    logic               busy_q, busy_d;
    logic               start;
    logic               wr_mem;
    logic [14:0]        wa;
    logic [7:0]         wbyte;
    logic [7:0]         wold;
    logic [SNAP_W*4-1:0] older;

    // Events arriving while an entry is being written are dropped; log_busy shows it.
    assign start  = err_log && err_device && ws_q == EELR_W_IDLE;
    assign wr_mem = ws_q == EELR_W_WRITE;
    assign wa     = mem_addr(wptr_q, k_q);
    assign wbyte  = ent_q[8*k_q +: 8];
    assign wold   = used_q[wptr_q] ? mem[wa] : 8'h00;

    always_comb begin
        ws_d   = ws_q;
        k_d    = k_q;
        wptr_d = wptr_q;
        idx_d  = idx_q;
        cnt_d  = cnt_q;
        ent_d  = ent_q;
        used_d = used_q;
        older  = ctrl_q[`EELR_CTRL_HIST_BIT] ?
                 {hist_q[3], hist_q[2], hist_q[1], hist_q[0]} : '0;
        case (ws_q)
            EELR_W_IDLE: begin
                if (start) begin
                    ent_d = {hour_q, 4'h0, state_q, cmp_ext_info, cmp_status, cmp_device,
                             cmp_lba_high, cmp_lba_mid, cmp_lba_low, cmp_count, cmp_error,
                             8'h00, hist_q[4], older};
                    if (cnt_q != 16'hFFFF) begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                    k_d  = '0;
                    ws_d = EELR_W_WRITE;
                end
            end
            EELR_W_WRITE: begin
                if (k_q == 7'(`EELR_ENTRY_BYTES - 1)) begin
                    used_d[wptr_q] = 1'b1;
                    idx_d  = wptr_q;
                    wptr_d = wptr_q + 8'h01;
                    ws_d   = EELR_W_IDLE;
                end else begin
                    k_d = k_q + 7'h01;
                end
            end
            default: ws_d = EELR_W_IDLE;
        endcase
        busy_d = ws_d == EELR_W_WRITE;
    end

    always_ff @(posedge clock) begin
        if (wr_mem) begin
            mem[wa] <= wbyte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sec_sum_q <= '{default: '0};
        end else if (wr_mem) begin
            sec_sum_q[wptr_q[7:2]] <= sec_sum_q[wptr_q[7:2]] - wold + wbyte;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ws_q   <= EELR_W_IDLE;
            k_q    <= '0;
            wptr_q <= '0;
            idx_q  <= '0;
            cnt_q  <= '0;
            ent_q  <= '0;
            used_q <= '0;
            busy_q <= 1'b0;
        end else begin
            ws_q   <= ws_d;
            k_q    <= k_d;
            wptr_q <= wptr_d;
            idx_q  <= idx_d;
            cnt_q  <= cnt_d;
            ent_q  <= ent_d;
            used_q <= used_d;
            busy_q <= busy_d;
        end
    end

    // Read side: byte view of the 64-sector log plus the local registers.
    logic [7:0] rdata_q, rdata_d;
    logic [5:0] rsec;
    logic [8:0] rb;
    logic [8:0] rrel;
    logic [1:0] rslot;
    logic [6:0] rofs;
    logic [7:0] rent;
    logic [7:0] hdr_sum;

    assign rsec    = reg_addr[14:9];
    assign rb      = reg_addr[8:0];
    assign hdr_sum = `EELR_LOG_VERSION + idx_q + 8'h00 + cnt_q[7:0] + cnt_q[15:8];

    always_comb begin
        rdata_d = 8'h00;
        rrel    = rb - `EELR_ENTRY0_OFS;
        if (rrel < 9'd124) begin
            rslot = 2'd0;
            rofs  = rrel[6:0];
        end else if (rrel < 9'd248) begin
            rslot = 2'd1;
            rofs  = 7'(rrel - 9'd124);
        end else if (rrel < 9'd372) begin
            rslot = 2'd2;
            rofs  = 7'(rrel - 9'd248);
        end else begin
            rslot = 2'd3;
            rofs  = 7'(rrel - 9'd372);
        end
        rent = {rsec, rslot};
        if (reg_rd) begin
            if (reg_addr[15]) begin
                if (reg_addr == `EELR_ADDR_CTRL) begin
                    rdata_d = ctrl_q;
                end else if (reg_addr == `EELR_ADDR_HOUR_LO) begin
                    rdata_d = hour_q[7:0];
                end else if (reg_addr == `EELR_ADDR_HOUR_HI) begin
                    rdata_d = hour_q[15:8];
                end else if (reg_addr == `EELR_ADDR_STATUS) begin
                    rdata_d = {7'h00, busy_q};
                end
            end else if (rb == `EELR_SECTOR_LAST) begin
                rdata_d = 8'h00 - sec_sum_q[rsec] - ((rsec == 6'd0) ? hdr_sum : 8'h00);
            end else if (rb >= `EELR_ENTRY0_OFS && rb < `EELR_ENTRY_END) begin
                rdata_d = used_q[rent] ? mem[mem_addr(rent, rofs)] : 8'h00;
            end else if (rsec == 6'd0) begin
                if (rb == `EELR_HDR_VERSION) begin
                    rdata_d = `EELR_LOG_VERSION;
                end else if (rb == `EELR_HDR_IDX_LO) begin
                    rdata_d = idx_q;
                end else if (rb == `EELR_HDR_CNT_LO) begin
                    rdata_d = cnt_q[7:0];
                end else if (rb == `EELR_HDR_CNT_HI) begin
                    rdata_d = cnt_q[15:8];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign log_busy  = busy_q;
    assign err_count = cnt_q;
    assign log_index = idx_q;
endmodule
`default_nettype wire

// ===== dv/eelr_props.sv
`timescale 1ns/1ps
`default_nettype none
module eelr_props (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        err_log,
    input wire logic        err_device,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        log_busy,
    input wire logic [15:0] err_count,
    input wire logic [7:0]  log_index
);
    logic [7:0] busy_cnt_q;
    logic [7:0] busy_cnt_d;
    logic       used_q;
    logic       used_d;
    logic       take;

    // An entry is accepted only while the writer is idle.
    assign take = err_log && err_device && !log_busy;

    always_comb begin
        busy_cnt_d = log_busy ? busy_cnt_q + 8'h01 : 8'h00;
        used_d     = used_q | (busy_cnt_q != 8'h00 && !log_busy);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_cnt_q <= 8'h00;
            used_q     <= 1'b0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            used_q     <= used_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    busy_len_a: assert property ($fell(log_busy) |-> busy_cnt_q == 8'h7C)
        else $error("entry write did not last one cycle per byte");
    busy_start_a: assert property (take |=> log_busy)
        else $error("accepted error did not start an entry");
    count_inc_a: assert property (take && err_count != 16'hFFFF |=>
        err_count == $past(err_count) + 16'h0001)
        else $error("error count did not step by one");
    count_sat_a: assert property (err_count == 16'hFFFF |=> err_count == 16'hFFFF)
        else $error("error count left its maximum");
    count_hold_a: assert property (!take |=> $stable(err_count))
        else $error("error count moved without an accepted error");
    idx_step_a: assert property ($fell(log_busy) && used_q |->
        log_index == $past(log_index) + 8'h01)
        else $error("index did not advance to the next slot");
    idx_first_a: assert property ($fell(log_busy) && !used_q |-> log_index == 8'h00)
        else $error("first entry index not zero");
    idx_hold_a: assert property (!$fell(log_busy) |-> $stable(log_index))
        else $error("index changed outside an entry completion");
    version_rd_a: assert property (reg_rd && reg_addr == 16'h0000 |=> reg_rdata == 8'h01)
        else $error("version byte wrong");
    idx_rd_a: assert property (reg_rd && reg_addr == 16'h0002 && !log_busy |=>
        reg_rdata == $past(log_index))
        else $error("index byte differs from index");
    cnt_rd_a: assert property (reg_rd && reg_addr == 16'h01F4 && !take |=>
        reg_rdata == $past(err_count[7:0]))
        else $error("count byte differs from count");

    cover property ($fell(log_busy) && used_q);
    cover property (err_log && !err_device);
    cover property (reg_rd && reg_addr == 16'h0002);
endmodule
`default_nettype wire

// ===== dv/eelr_host.sv
`timescale 1ns/1ps
`default_nettype none
module eelr_host (
    input  wire logic              clock,
    output logic                   tf_wr,
    output eelr_pkg::eelr_tf_sel_t tf_sel,
    output logic [7:0]             tf_wdata,
    output logic [15:0]            reg_addr,
    output logic [7:0]             reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [7:0]        reg_rdata
);
    import eelr_pkg::*;

    initial begin
        tf_wr = 1'b0;
        tf_sel = EELR_TF_DEVCTL;
        tf_wdata = 8'h00;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released data and register address lines show the inverse so a stale value never looks valid; tf_sel is held.
    task automatic tfw(input eelr_tf_sel_t s, input logic [7:0] d);
        @(posedge clock);
        tf_wr <= 1'b1;
        tf_sel <= s;
        tf_wdata <= d;
        @(posedge clock);
        tf_wr <= 1'b0;
        tf_wdata <= ~d;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_eelr_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eelr_top;
    import eelr_pkg::*;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic         hw_reset_evt = 1'b0;
    logic         err_log = 1'b0;
    logic         err_device = 1'b0;
    logic [3:0]   dev_state = 4'h0;
    logic [7:0]   cmp_error = 8'h00, cmp_device = 8'h00, cmp_status = 8'h00;
    logic [15:0]  cmp_count = 16'h0000, cmp_lba_low = 16'h0000;
    logic [15:0]  cmp_lba_mid = 16'h0000, cmp_lba_high = 16'h0000;
    logic [151:0] cmp_ext_info = '0;
    eelr_tf_sel_t tf_sel;
    logic         tf_wr, reg_wr, reg_rd, log_busy;
    logic [7:0]   tf_wdata, reg_wdata, reg_rdata, log_index;
    logic [15:0]  reg_addr, dev_err_count;
    localparam int CPM = 4, MPH = 5;
    int           err_count = 0, tests_run = 0, errs = 0, cyc = 0;
    logic [31:0]  seed;
    logic [7:0]   cur[7], prv[7], desc[34];
    logic [7:0]   snap[5][18] = '{default: '{default: 8'h00}};
    logic [3:0]   st_exp;
    bit           hist_on = 1'b1;

    eelr_top #(.CYC_PER_MS(CPM), .MS_PER_HOUR(MPH)) i_eelr_top (
        .clock(clock), .rst_n(rst_n), .tf_wr(tf_wr), .tf_sel(tf_sel), .tf_wdata(tf_wdata),
        .hw_reset_evt(hw_reset_evt), .dev_state(dev_state), .err_log(err_log),
        .err_device(err_device), .err_is_reset(1'b0), .cmp_error(cmp_error),
        .cmp_count(cmp_count), .cmp_lba_low(cmp_lba_low), .cmp_lba_mid(cmp_lba_mid),
        .cmp_lba_high(cmp_lba_high), .cmp_device(cmp_device), .cmp_status(cmp_status),
        .cmp_ext_info(cmp_ext_info), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .log_busy(log_busy),
        .err_count(dev_err_count), .log_index(log_index));
    eelr_host i_eelr_host (
        .clock(clock), .tf_wr(tf_wr), .tf_sel(tf_sel), .tf_wdata(tf_wdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    initial begin
        forever #5 clock = ~clock;
    end

    // Edges since reset release; read before the edge's update, so it matches the sample.
    always @(posedge clock) cyc <= rst_n ? cyc + 1 : 0;

    function automatic logic [7:0] ms_byte(input int i);
        return 8'((cyc / CPM) >> (8 * i));
    endfunction

    function automatic logic [7:0] lfsr_byte();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // The bench mirrors the task file so each snapshot is predicted independently.
    task automatic tfw(input eelr_tf_sel_t s, input logic [7:0] d);
        i_eelr_host.tfw(s, d);
        if (s == EELR_TF_COMMAND) begin
            for (int i = 0; i < 4; i++)
                snap[i] = snap[i + 1];
            snap[4] = '{cur[0], cur[1], prv[1], cur[2], prv[2], cur[3], prv[3], cur[4], prv[4],
                        cur[5], prv[5], cur[6], d, 8'h00,
                        ms_byte(0), ms_byte(1), ms_byte(2), ms_byte(3)};
            st_exp = (dev_state <= 4'h4) ? dev_state : 4'h0;
        end else begin
            prv[s] = cur[s];
            cur[s] = d;
        end
    endtask

    task automatic fill();
        for (int i = 0; i < 14; i++)
            tfw(eelr_tf_sel_t'(i % 7), lfsr_byte());
    endtask

    task automatic hwrst();
        @(posedge clock);
        hw_reset_evt <= 1'b1;
        @(posedge clock);
        hw_reset_evt <= 1'b0;
        for (int i = 0; i < 4; i++)
            snap[i] = snap[i + 1];
        snap[4] = '{default: 8'h00};
        snap[4][0] = 8'hFF;
        for (int i = 0; i < 4; i++)
            snap[4][14 + i] = ms_byte(i);
    endtask

    task automatic log_err(input logic dev);
        int n;
        n = 0;
        foreach (desc[i])
            desc[i] = lfsr_byte();
        desc[0] = 8'h00;
        desc[31] = {4'h0, st_exp};
        @(posedge clock);
        err_log <= 1'b1;
        err_device <= dev;
        cmp_error <= desc[1];
        cmp_count <= {desc[3], desc[2]};
        cmp_lba_low <= {desc[5], desc[4]};
        cmp_lba_mid <= {desc[7], desc[6]};
        cmp_lba_high <= {desc[9], desc[8]};
        cmp_device <= desc[10];
        cmp_status <= desc[11];
        for (int i = 0; i < 19; i++)
            cmp_ext_info[8 * i +: 8] <= desc[12 + i];
        @(posedge clock);
        err_log <= 1'b0;
        {desc[33], desc[32]} = 16'(cyc / (CPM * MPH));
        do @(negedge clock); while (log_busy === 1'b1 && ++n < 300);
        check(n < 300, 1, "entry write hung");
        if (dev)
            errs++;
        check(log_index, errs == 0 ? 0 : (errs - 1) % 256, "index");
        check(dev_err_count, errs, "error count");
    endtask

    task automatic chk_entry(input int slot);
        logic [7:0]  x;
        logic [15:0] base;
        base = {1'b0, slot[7:2], 9'(4 + 124 * slot[1:0])};
        for (int k = 0; k < 124; k++) begin
            i_eelr_host.rd(base + 16'(k), x);
            if (k < 90)
                check(x, (hist_on || k >= 72) ? snap[k / 18][k % 18] : 0, "snapshot");
            else
                check(x, desc[k - 90], "description");
        end
    endtask

    task automatic scan(input int s, input bit empty);
        logic [7:0] x, sum;
        sum = 8'h00;
        for (int b = 0; b < 511; b++) begin
            i_eelr_host.rd({1'b0, 6'(s), 9'(b)}, x);
            sum += x;
            if (empty && b > 0)
                check(x, 0, "unused byte");
        end
        i_eelr_host.rd({1'b0, 6'(s), 9'h1FF}, x);
        check(8'(sum + x), 0, "sector sum");
    endtask

    initial begin
        logic [7:0] x;
        seed = 32'hCA1C4A1E;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        i_eelr_host.rd(16'h0000, x);
        check(x, 8'h01, "version");
        scan(0, 1'b1);
        i_eelr_host.wr(16'h8003, 8'h5A);
        i_eelr_host.rd(16'h8003, x);
        check(x, 8'h00, "status write");
        i_eelr_host.rd(16'hC000, x);
        check(x, 8'h00, "unmapped read");
        fill();
        tfw(EELR_TF_COMMAND, lfsr_byte());
        hwrst();
        fill();
        tfw(EELR_TF_COMMAND, lfsr_byte());
        log_err(1'b1);
        chk_entry(0);
        scan(0, 1'b0);
        log_err(1'b0);
        repeat (259) begin
            @(posedge clock);
            dev_state <= 4'(lfsr_byte() % 8'h06);
            tfw(eelr_tf_sel_t'(lfsr_byte() % 8'h07), lfsr_byte());
            tfw(EELR_TF_COMMAND, lfsr_byte());
            log_err(1'b1);
        end
        i_eelr_host.wr(16'h8000, 8'h00);
        i_eelr_host.rd(16'h8000, x);
        check(x, 8'h00, "control read");
        hist_on = 1'b0;
        tfw(EELR_TF_COMMAND, lfsr_byte());
        log_err(1'b1);
        chk_entry(4);
        scan(1, 1'b0);
        i_eelr_host.wr(16'h8002, 8'hA5);
        i_eelr_host.rd(16'h8002, x);
        check(x, 8'hA5, "hour restore");
        finish_test();
    end

    initial begin
        #1000000;
        err_count++;
        finish_test();
    end
endmodule

bind eelr_top eelr_props i_eelr_props (
    .clock(clock), .rst_n(rst_n), .err_log(err_log), .err_device(err_device),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .log_busy(log_busy),
    .err_count(err_count), .log_index(log_index));
`default_nettype wire
